// File: rtl/pinctl_defs.svh
// Widths, field positions and reset values for the port pin and enable control
`ifndef PINCTL_DEFS_SVH
`define PINCTL_DEFS_SVH

// ==================================================
// Port widths
`define PORT_W        4
`define PORT3_W       3
`define PIN_ALL_W     11

// ==================================================
// Bit positions inside the shared groups
`define A_SDA_BIT     3
`define A_SCL_BIT     2
`define A_SERIAL0_CLOCK_PIN_BIT    1
`define A_SO0_BIT     0
`define B_SI0_BIT     3
`define B_SERIAL1_CLOCK_PIN_BIT    2
`define B_SO1_BIT     1
`define B_SI1_BIT     0

// ==================================================
// Reset values
`define DIR_RST       4'h0
`define DATA_RST      4'h0
`define DIR3_RST      3'h0
`define DATA3_RST     3'h0

// ==================================================
// Enable pin delay counter
`define CE_DLY_W      4
`define CE_DLY_ZERO   4'h0
`define CE_DLY_ONE    4'h1

`endif

// File: rtl/pinctl_pkg.sv
// Types shared by the port pin and enable control modules
`include "pinctl_defs.svh"

package pinctl_pkg;

   // ==================================================
   // Modes and selectors
   typedef enum logic [1:0] {S0_OFF, S0_TWO_WIRE, S0_THREE_WIRE} serial0_mode_e;
   typedef enum logic [1:0] {SEL_A, SEL_B, SEL_D} port_sel_e;
   typedef enum logic [1:0] {CE_IDLE, CE_WAIT_EDGE, CE_DELAY} ce_state_e;

   // ==================================================
   // Enable pin controller state
   typedef struct packed {
      logic                   sync1;
      logic                   sync2;
      logic                   prev;
      logic                   tmr_prev;
      ce_state_e              state;
      logic [`CE_DLY_W-1:0]   cnt;
      logic                   pll_en;
      logic                   ce_reset;
      logic                   ce_int;
   } ce_ctl_s;

   // ==================================================
   // Port block state
   typedef struct packed {
      logic [`PIN_ALL_W-1:0]  in1;
      logic [`PIN_ALL_W-1:0]  in2;
      logic [`PORT_W-1:0]     dir_a;
      logic [`PORT_W-1:0]     dir_b;
      logic [`PORT3_W-1:0]    dir_d;
      logic [`PORT_W-1:0]     dat_a;
      logic [`PORT_W-1:0]     dat_b;
      logic [`PORT3_W-1:0]    dat_d;
      logic [`PORT_W-1:0]     a_out;
      logic [`PORT_W-1:0]     a_oe;
      logic [`PORT_W-1:0]     b_out;
      logic [`PORT_W-1:0]     b_oe;
      logic [`PORT3_W-1:0]    d_out;
      logic [`PORT3_W-1:0]    d_oe;
   } port_s;

endpackage

// File: rtl/enable_pin_ctl.sv
// Enable pin synchroniser, PLL gate, timer-aligned enable reset and falling-edge interrupt
`timescale 1ns/10ps
`include "pinctl_defs.svh"

module enable_pin_ctl
(
   input  wire logic                  core_clk,
   input  wire logic                  reset_n,
   input  wire logic                  clk_en,
   input  wire logic                  enable_pin,
   input  wire logic                  timer_pulse,
   input  wire logic                  pll_sw_enable,
   input  wire logic [`CE_DLY_W-1:0]  ce_reset_delay,
   output logic                       pll_enable,
   output logic                       ce_reset,
   output logic                       ce_int
);

   pinctl_pkg::ce_ctl_s cur_ff;
   pinctl_pkg::ce_ctl_s nxt_cur;

   always_comb
   begin
      nxt_cur          = cur_ff;
      nxt_cur.sync1    = enable_pin;
      nxt_cur.sync2    = cur_ff.sync1;
      nxt_cur.prev     = cur_ff.sync2;
      nxt_cur.tmr_prev = timer_pulse;
      nxt_cur.ce_reset = 1'b0;
      // PLL runs only with the pin high; software alone cannot keep it on
      nxt_cur.pll_en   = cur_ff.sync2 & pll_sw_enable;
      nxt_cur.ce_int   = cur_ff.prev & ~cur_ff.sync2;
      case (cur_ff.state)
         pinctl_pkg::CE_IDLE:
         begin
            if (cur_ff.sync2 && !cur_ff.prev)
            begin
               nxt_cur.state = pinctl_pkg::CE_WAIT_EDGE;
            end
         end
         pinctl_pkg::CE_WAIT_EDGE:
         begin
            if (!cur_ff.sync2)
            begin
               nxt_cur.state = pinctl_pkg::CE_IDLE;
            end
            else if (timer_pulse && !cur_ff.tmr_prev)
            begin
               if (ce_reset_delay == `CE_DLY_ZERO)
               begin
                  nxt_cur.ce_reset = 1'b1;
                  nxt_cur.state    = pinctl_pkg::CE_IDLE;
               end
               else
               begin
                  nxt_cur.cnt   = ce_reset_delay;
                  nxt_cur.state = pinctl_pkg::CE_DELAY;
               end
            end
         end
         pinctl_pkg::CE_DELAY:
         begin
            // Delay counts further timer edges so the reset stays timer aligned
            if (!cur_ff.sync2)
            begin
               nxt_cur.state = pinctl_pkg::CE_IDLE;
            end
            else if (timer_pulse && !cur_ff.tmr_prev)
            begin
               if (cur_ff.cnt == `CE_DLY_ONE)
               begin
                  nxt_cur.ce_reset = 1'b1;
                  nxt_cur.state    = pinctl_pkg::CE_IDLE;
               end
               nxt_cur.cnt = cur_ff.cnt - `CE_DLY_ONE;
            end
         end
         default:
         begin
            nxt_cur.state = pinctl_pkg::CE_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         cur_ff <= '0;
      end
      else if (clk_en)
      begin
         cur_ff <= nxt_cur;
      end
   end

   assign pll_enable = cur_ff.pll_en;
   assign ce_reset   = cur_ff.ce_reset;
   assign ce_int     = cur_ff.ce_int;

endmodule

// File: rtl/port_pin_function_and_enable_control.sv
// Shared port pin muxing, general port direction and the enable pin controller
//
// Functional notes
// - Each shared group pin direction is set per bit by software.
// - Serial 0 two-wire mode puts open-drain data and clock on group A pins.
// - Serial 0 three-wire mode routes clock, data out, data in to pins.
// - Serial 1 three-wire mode routes clock, data out, data in to group B.
// - Enable pin high lets software run the PLL synthesizer.
// - Enable pin low forces the PLL synthesizer off.
// - Enable reset fires at next basic timer rising edge after pin rises.
// - Software can add further delay before the enable reset.
// - Falling edge on enable pin raises an interrupt.
// - reset_n returns all port pins to input; watchdog reset, with clock running, only pins without a serial function; enable reset none.
`timescale 1ns/10ps
`include "pinctl_defs.svh"

module port_pin_function_and_enable_control
(
   input  wire logic                   core_clk,
   input  wire logic                   reset_n,
   input  wire logic                   clk_en,
   input  wire logic                   watchdog_stack_reset,
   input  wire logic                   clock_stopped,
   // Software port writes
   input  wire pinctl_pkg::port_sel_e  port_sel,
   input  wire logic                   dir_we,
   input  wire logic                   data_we,
   input  wire logic [`PORT_W-1:0]     wdata,
   // Serial interface side
   input  wire pinctl_pkg::serial0_mode_e serial0_mode,
   input  wire logic                   serial1_enable,
   input  wire logic                   sda_drive_low,
   input  wire logic                   scl_drive_low,
   input  wire logic                   serial0_clock_out,
   input  wire logic                   serial0_clock_is_out,
   input  wire logic                   serial0_data_out,
   input  wire logic                   serial1_clock_out,
   input  wire logic                   serial1_clock_is_out,
   input  wire logic                   serial1_data_out,
   output logic                        sda_in,
   output logic                        scl_in,
   output logic                        serial0_clock_in,
   output logic                        serial0_data_in,
   output logic                        serial1_clock_in,
   output logic                        serial1_data_in,
   // Port read-back
   output logic [`PORT_W-1:0]          port_a_rd,
   output logic [`PORT_W-1:0]          port_b_rd,
   output logic [`PORT3_W-1:0]         port_d_rd,
   // Pins
   input  wire logic [`PORT_W-1:0]     shared_port_group_a_in,
   output logic [`PORT_W-1:0]          shared_port_group_a_out,
   output logic [`PORT_W-1:0]          shared_port_group_a_oe,
   input  wire logic [`PORT_W-1:0]     shared_port_group_b_in,
   output logic [`PORT_W-1:0]          shared_port_group_b_out,
   output logic [`PORT_W-1:0]          shared_port_group_b_oe,
   input  wire logic [`PORT3_W-1:0]    three_bit_port_in,
   output logic [`PORT3_W-1:0]         three_bit_port_out,
   output logic [`PORT3_W-1:0]         three_bit_port_oe,
   // Enable pin
   input  wire logic                   enable_pin,
   input  wire logic                   timer_pulse,
   input  wire logic                   pll_sw_enable,
   input  wire logic [`CE_DLY_W-1:0]   ce_reset_delay,
   output logic                        pll_enable,
   output logic                        ce_reset,
   output logic                        ce_int
);

   // All port state in one register; nxt_cur is its next value
   pinctl_pkg::port_s cur_ff;
   pinctl_pkg::port_s nxt_cur;

   // ==================================================
   // Enable pin controller
   // Its reset pulse only leaves the block; no port state clears on it
   enable_pin_ctl u_enable_pin_ctl
   (
      .core_clk       (core_clk),
      .reset_n        (reset_n),
      .clk_en         (clk_en),
      .enable_pin     (enable_pin),
      .timer_pulse    (timer_pulse),
      .pll_sw_enable  (pll_sw_enable),
      .ce_reset_delay (ce_reset_delay),
      .pll_enable     (pll_enable),
      .ce_reset       (ce_reset),
      .ce_int         (ce_int)
   );

   // ==================================================
   // Port state and pin mux
   always_comb
   begin
      nxt_cur     = cur_ff;

      // Pins are asynchronous: two flops before anything reads them
      nxt_cur.in1 = {three_bit_port_in, shared_port_group_b_in, shared_port_group_a_in};
      nxt_cur.in2 = cur_ff.in1;

      // Stopped clock holds everything except the input synchronisers
      if (!clock_stopped)
      begin
         // Reset beats a write in the same cycle; data is kept
         if (watchdog_stack_reset)
         begin
            nxt_cur.dir_a = `DIR_RST;
            nxt_cur.dir_b = `DIR_RST;
            nxt_cur.dir_d = `DIR3_RST;
         end
         else
         begin
            // One port per write; the select picks which
            if (dir_we && port_sel == pinctl_pkg::SEL_A)
            begin
               nxt_cur.dir_a = wdata;
            end
            else if (dir_we && port_sel == pinctl_pkg::SEL_B)
            begin
               nxt_cur.dir_b = wdata;
            end
            else if (dir_we && port_sel == pinctl_pkg::SEL_D)
            begin
               nxt_cur.dir_d = wdata[`PORT3_W-1:0];
            end

            // Data is stored for input pins too, ready for a later turn-round
            if (data_we && port_sel == pinctl_pkg::SEL_A)
            begin
               nxt_cur.dat_a = wdata;
            end
            else if (data_we && port_sel == pinctl_pkg::SEL_B)
            begin
               nxt_cur.dat_b = wdata;
            end
            else if (data_we && port_sel == pinctl_pkg::SEL_D)
            begin
               nxt_cur.dat_d = wdata[`PORT3_W-1:0];
            end
         end

         // General mode: push-pull, except A3/A2 which are open-drain
         nxt_cur.a_out = nxt_cur.dat_a;
         nxt_cur.a_oe  = nxt_cur.dir_a;
         nxt_cur.a_out[`A_SDA_BIT] = 1'b0;
         nxt_cur.a_out[`A_SCL_BIT] = 1'b0;
         nxt_cur.a_oe[`A_SDA_BIT]  = nxt_cur.dir_a[`A_SDA_BIT] & ~nxt_cur.dat_a[`A_SDA_BIT];
         nxt_cur.a_oe[`A_SCL_BIT]  = nxt_cur.dir_a[`A_SCL_BIT] & ~nxt_cur.dat_a[`A_SCL_BIT];
         nxt_cur.b_out = nxt_cur.dat_b;
         nxt_cur.b_oe  = nxt_cur.dir_b;
         nxt_cur.d_out = nxt_cur.dat_d;
         nxt_cur.d_oe  = nxt_cur.dir_d;

         // Serial functions override only their own pins
         if (serial0_mode == pinctl_pkg::S0_TWO_WIRE)
         begin
            // Only pull low; the bus resistor supplies the high level
            nxt_cur.a_oe[`A_SDA_BIT] = sda_drive_low;
            nxt_cur.a_oe[`A_SCL_BIT] = scl_drive_low;
         end
         else if (serial0_mode == pinctl_pkg::S0_THREE_WIRE)
         begin
            nxt_cur.a_out[`A_SERIAL0_CLOCK_PIN_BIT] = serial0_clock_out;
            nxt_cur.a_oe[`A_SERIAL0_CLOCK_PIN_BIT]  = serial0_clock_is_out;
            nxt_cur.a_out[`A_SO0_BIT]  = serial0_data_out;
            nxt_cur.a_oe[`A_SO0_BIT]   = 1'b1;
            // Serial 0 data input sits on group B
            nxt_cur.b_oe[`B_SI0_BIT]   = 1'b0;
         end

         // Serial 1 uses B2..B0 and leaves B3 to serial 0
         if (serial1_enable)
         begin
            nxt_cur.b_out[`B_SERIAL1_CLOCK_PIN_BIT] = serial1_clock_out;
            nxt_cur.b_oe[`B_SERIAL1_CLOCK_PIN_BIT]  = serial1_clock_is_out;
            nxt_cur.b_out[`B_SO1_BIT]  = serial1_data_out;
            nxt_cur.b_oe[`B_SO1_BIT]   = 1'b1;
            nxt_cur.b_oe[`B_SI1_BIT]   = 1'b0;
         end
      end
   end

   // ==================================================
   // State register
   // Enable reset is not wired here, so port state survives it
   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         cur_ff <= '0;
      end
      else if (clk_en)
      begin
         cur_ff <= nxt_cur;
      end
   end

   // ==================================================
   // Outputs
   // Drivers come straight from the register
   assign shared_port_group_a_out = cur_ff.a_out;
   assign shared_port_group_a_oe  = cur_ff.a_oe;
   assign shared_port_group_b_out = cur_ff.b_out;
   assign shared_port_group_b_oe  = cur_ff.b_oe;
   assign three_bit_port_out      = cur_ff.d_out;
   assign three_bit_port_oe       = cur_ff.d_oe;

   // ==================================================
   // Synchronised pin levels
   assign port_a_rd               = cur_ff.in2[`PORT_W-1:0];
   assign port_b_rd               = cur_ff.in2[2*`PORT_W-1:`PORT_W];
   assign port_d_rd               = cur_ff.in2[`PIN_ALL_W-1:2*`PORT_W];
   assign sda_in                  = cur_ff.in2[`A_SDA_BIT];
   assign scl_in                  = cur_ff.in2[`A_SCL_BIT];
   assign serial0_clock_in        = cur_ff.in2[`A_SERIAL0_CLOCK_PIN_BIT];
   assign serial0_data_in         = cur_ff.in2[`PORT_W+`B_SI0_BIT];
   assign serial1_clock_in        = cur_ff.in2[`PORT_W+`B_SERIAL1_CLOCK_PIN_BIT];
   assign serial1_data_in         = cur_ff.in2[`PORT_W+`B_SI1_BIT];

endmodule

// File: test/port_pin_function_and_enable_control_properties.sv
// Port-level assertions for the pin function and enable control block
`timescale 1ns/10ps
// =====
// Checker
module pin_ctl_props
(
   input wire logic                      core_clk,
   input wire logic                      reset_n,
   input wire logic                      clk_en,
   input wire logic                      watchdog_stack_reset,
   input wire logic                      clock_stopped,
   input wire pinctl_pkg::port_sel_e     port_sel,
   input wire logic                      dir_we,
   input wire logic [3:0]                wdata,
   input wire pinctl_pkg::serial0_mode_e serial0_mode,
   input wire logic                      serial1_enable,
   input wire logic                      sda_drive_low,
   input wire logic                      scl_drive_low,
   input wire logic                      serial0_clock_out,
   input wire logic                      serial0_clock_is_out,
   input wire logic                      serial0_data_out,
   input wire logic                      serial1_clock_is_out,
   input wire logic                      serial1_data_out,
   input wire logic [3:0]                shared_port_group_a_out,
   input wire logic [3:0]                shared_port_group_a_oe,
   input wire logic [3:0]                shared_port_group_b_out,
   input wire logic [3:0]                shared_port_group_b_oe,
   input wire logic [2:0]                three_bit_port_oe,
   input wire logic                      enable_pin,
   input wire logic                      timer_pulse,
   input wire logic                      pll_sw_enable,
   input wire logic                      pll_enable,
   input wire logic                      ce_reset,
   input wire logic                      ce_int
);
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (!reset_n);

   // Five samples cover the two-flop sync plus the output register
   property p_pll_run;
      (enable_pin && pll_sw_enable && clk_en)[*5] |-> pll_enable;
   endproperty
   a_pll_run: assert property (p_pll_run) else $error("pll not running");

   property p_pll_off;
      (!enable_pin && clk_en)[*5] |-> !pll_enable;
   endproperty
   a_pll_off: assert property (p_pll_off) else $error("pll on with pin low");

   property p_ce_rst;
      ce_reset |-> ($past(timer_pulse) && !$past(timer_pulse, 2)) ##1 !ce_reset;
   endproperty
   a_ce_rst: assert property (p_ce_rst) else $error("enable reset off timer edge");

   property p_ce_int;
      $fell(enable_pin) && clk_en |-> ##3 ce_int ##1 !ce_int;
   endproperty
   a_ce_int: assert property (p_ce_int) else $error("no fall interrupt");

   property p_wdt;
      watchdog_stack_reset && clk_en && !clock_stopped && !serial1_enable &&
         serial0_mode == pinctl_pkg::S0_OFF |=> shared_port_group_a_oe == 4'h0 &&
         shared_port_group_b_oe == 4'h0 && three_bit_port_oe == 3'h0;
   endproperty
   a_wdt: assert property (p_wdt) else $error("pins not input after reset");

   property p_hold;
      clock_stopped |=> $stable(shared_port_group_a_oe) && $stable(shared_port_group_b_oe)
         && $stable(three_bit_port_oe);
   endproperty
   a_hold: assert property (p_hold) else $error("pins moved while stopped");

   property p_dir_b;
      dir_we && clk_en && !clock_stopped && !watchdog_stack_reset && !serial1_enable &&
         port_sel == pinctl_pkg::SEL_B && serial0_mode != pinctl_pkg::S0_THREE_WIRE
         |=> shared_port_group_b_oe == $past(wdata);
   endproperty
   a_dir_b: assert property (p_dir_b) else $error("direction write lost");

   property p_two;
      serial0_mode == pinctl_pkg::S0_TWO_WIRE && clk_en && !clock_stopped |=>
         shared_port_group_a_oe[3:2] == $past({sda_drive_low, scl_drive_low}) &&
         shared_port_group_a_out[3:2] == 2'h0;
   endproperty
   a_two: assert property (p_two) else $error("two-wire pins wrong");

   property p_three0;
      serial0_mode == pinctl_pkg::S0_THREE_WIRE && clk_en && !clock_stopped |=>
         shared_port_group_a_oe[1:0] == {$past(serial0_clock_is_out), 1'b1} &&
         shared_port_group_a_out[1:0] == $past({serial0_clock_out, serial0_data_out}) &&
         !shared_port_group_b_oe[3];
   endproperty
   a_three0: assert property (p_three0) else $error("serial0 pins wrong");

   property p_ser1;
      serial1_enable && clk_en && !clock_stopped |=> shared_port_group_b_oe[1:0] == 2'h2
         && shared_port_group_b_oe[2] == $past(serial1_clock_is_out) &&
         shared_port_group_b_out[1] == $past(serial1_data_out);
   endproperty
   a_ser1: assert property (p_ser1) else $error("serial1 pins wrong");
endmodule

bind port_pin_function_and_enable_control pin_ctl_props i_props
(
   .core_clk, .reset_n, .clk_en, .watchdog_stack_reset, .clock_stopped, .port_sel, .dir_we,
   .wdata, .serial0_mode, .serial1_enable, .sda_drive_low, .scl_drive_low,
   .serial0_clock_out, .serial0_clock_is_out, .serial0_data_out, .serial1_clock_is_out,
   .serial1_data_out, .shared_port_group_a_out, .shared_port_group_a_oe,
   .shared_port_group_b_out, .shared_port_group_b_oe, .three_bit_port_oe, .enable_pin,
   .timer_pulse, .pll_sw_enable, .pll_enable, .ce_reset, .ce_int
);

// File: test/pin_far_side.sv
// Far side of the port pins: pull-ups on the open-drain pair, board drive elsewhere
`timescale 1ns/10ps
// =====
// Wire resolution
module pin_far_side
(
   input  wire logic [3:0] a_out,
   input  wire logic [3:0] a_oe,
   input  wire logic [3:0] b_out,
   input  wire logic [3:0] b_oe,
   input  wire logic [2:0] d_out,
   input  wire logic [2:0] d_oe,
   input  wire logic [3:0] ext_a,
   input  wire logic [3:0] ext_b,
   input  wire logic [2:0] ext_d,
   output logic      [3:0] a_pin,
   output logic      [3:0] b_pin,
   output logic      [2:0] d_pin
);
   // Released open-drain line shows the pull-up unless a peer pulls it low
   assign a_pin[3:2] = ~a_oe[3:2] & ext_a[3:2];
   assign a_pin[1:0] = (a_oe[1:0] & a_out[1:0]) | (~a_oe[1:0] & ext_a[1:0]);
   assign b_pin = (b_oe & b_out) | (~b_oe & ext_b);
   assign d_pin = (d_oe & d_out) | (~d_oe & ext_d);
endmodule

// File: test/port_pin_function_and_enable_control_tb_top.sv
// Self-checking bench for the port pin function and enable control block
`timescale 1ns/10ps
module port_pin_function_and_enable_control_tb_top;
   // =====
   // Signals
   logic core_clk = 1'b0;
   logic reset_n, clk_en, watchdog_stack_reset, clock_stopped, dir_we, data_we;
   logic serial1_enable, sda_drive_low, scl_drive_low, serial0_clock_out;
   logic serial0_clock_is_out, serial0_data_out, serial1_clock_out, serial1_clock_is_out;
   logic serial1_data_out, enable_pin, timer_pulse, pll_sw_enable, pll_enable, ce_reset;
   logic sda_in, scl_in, serial0_clock_in, serial0_data_in, serial1_clock_in;
   logic serial1_data_in, ce_int;
   logic [3:0] wdata, ce_reset_delay, port_a_rd, port_b_rd, ext_a, ext_b;
   logic [3:0] shared_port_group_a_in, shared_port_group_a_out, shared_port_group_a_oe;
   logic [3:0] shared_port_group_b_in, shared_port_group_b_out, shared_port_group_b_oe;
   logic [2:0] port_d_rd, three_bit_port_in, three_bit_port_out, three_bit_port_oe, ext_d;
   pinctl_pkg::port_sel_e     port_sel;
   pinctl_pkg::serial0_mode_e serial0_mode;
   int mismatches = 0, checked = 0, cyc = 0, hits;

   port_pin_function_and_enable_control i_dut
   (
      .core_clk, .reset_n, .clk_en, .watchdog_stack_reset, .clock_stopped, .port_sel,
      .dir_we, .data_we, .wdata, .serial0_mode, .serial1_enable, .sda_drive_low,
      .scl_drive_low, .serial0_clock_out, .serial0_clock_is_out, .serial0_data_out,
      .serial1_clock_out, .serial1_clock_is_out, .serial1_data_out, .sda_in, .scl_in,
      .serial0_clock_in, .serial0_data_in, .serial1_clock_in, .serial1_data_in, .port_a_rd,
      .port_b_rd, .port_d_rd, .shared_port_group_a_in, .shared_port_group_a_out,
      .shared_port_group_a_oe, .shared_port_group_b_in, .shared_port_group_b_out,
      .shared_port_group_b_oe, .three_bit_port_in, .three_bit_port_out, .three_bit_port_oe,
      .enable_pin, .timer_pulse, .pll_sw_enable, .ce_reset_delay, .pll_enable, .ce_reset,
      .ce_int
   );

   pin_far_side i_far
   (
      .a_out(shared_port_group_a_out), .a_oe(shared_port_group_a_oe),
      .b_out(shared_port_group_b_out), .b_oe(shared_port_group_b_oe),
      .d_out(three_bit_port_out), .d_oe(three_bit_port_oe), .ext_a(ext_a), .ext_b(ext_b),
      .ext_d(ext_d), .a_pin(shared_port_group_a_in), .b_pin(shared_port_group_b_in),
      .d_pin(three_bit_port_in)
   );

   always #25 core_clk = ~core_clk;

   // =====
   // Helpers
   task automatic step(input int n);
      repeat (n) @(negedge core_clk);
   endtask

   task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
      checked++;
      if (got !== exp)
      begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Strobe dropped a cycle later so no signal is set twice in one step
   task automatic wr(input pinctl_pkg::port_sel_e s, input logic dir, input logic [3:0] v);
      port_sel = s;
      dir_we = dir;
      data_we = !dir;
      wdata = v;
      step(1);
      {dir_we, data_we} = 2'h0;
      step(1);
   endtask

   task automatic tick(output int n);
      n = 0;
      timer_pulse = 1'b1;
      step(1);
      timer_pulse = 1'b0;
      repeat (3)
      begin
         n += ce_reset;
         step(1);
      end
   endtask

   task automatic report_and_stop;
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // =====
   // Scenarios
   task automatic t_ports;
      chk("a_oe", 4'h0, shared_port_group_a_oe);
      chk("d_oe", 4'h0, {1'b0, three_bit_port_oe});
      wr(pinctl_pkg::SEL_A, 1'b0, 4'h5);
      wr(pinctl_pkg::SEL_A, 1'b1, 4'hf);
      chk("a_oe", 4'hb, shared_port_group_a_oe);
      chk("a_out", 4'h1, shared_port_group_a_out);
      wr(pinctl_pkg::SEL_B, 1'b0, 4'hc);
      wr(pinctl_pkg::SEL_B, 1'b1, 4'ha);
      chk("b_drv", 4'h8, shared_port_group_b_oe & shared_port_group_b_out);
      wr(pinctl_pkg::SEL_D, 1'b0, 4'h6);
      wr(pinctl_pkg::SEL_D, 1'b1, 4'h5);
      chk("d_oe", 4'h5, {1'b0, three_bit_port_oe});
      step(2);
      chk("a_rd", 4'h5, port_a_rd);
      chk("b_rd", 4'h9, port_b_rd);
      chk("d_rd", 4'h6, {1'b0, port_d_rd});
   endtask

   task automatic t_hold_wdt;
      clock_stopped = 1'b1;
      wr(pinctl_pkg::SEL_D, 1'b1, 4'h0);
      clock_stopped = 1'b0;
      clk_en = 1'b0;
      wr(pinctl_pkg::SEL_D, 1'b1, 4'h0);
      clk_en = 1'b1;
      chk("d_oe", 4'h5, {1'b0, three_bit_port_oe});
      watchdog_stack_reset = 1'b1;
      step(1);
      watchdog_stack_reset = 1'b0;
      chk("a_oe", 4'h0, shared_port_group_a_oe);
      chk("b_oe", 4'h0, shared_port_group_b_oe);
      wr(pinctl_pkg::SEL_D, 1'b1, 4'h7);
      chk("d_drv", 4'h6, {1'b0, three_bit_port_oe & three_bit_port_out});
   endtask

   task automatic t_serial;
      serial0_mode = pinctl_pkg::S0_TWO_WIRE;
      sda_drive_low = 1'b1;
      step(4);
      chk("od_oe", 4'h2, {2'h0, shared_port_group_a_oe[3:2]});
      chk("od_in", 4'h1, {2'h0, sda_in, scl_in});
      serial0_mode = pinctl_pkg::S0_THREE_WIRE;
      {serial0_clock_out, serial0_clock_is_out, serial1_enable, serial1_data_out,
       serial1_clock_is_out} = 5'h1f;
      step(4);
      chk("s0_oe", 4'h3, {2'h0, shared_port_group_a_oe[1:0]});
      chk("s0_in", 4'h3, {2'h0, serial0_clock_in, serial0_data_in});
      chk("s1_oe", 4'h6, shared_port_group_b_oe);
      chk("s1_out", 4'h2, shared_port_group_b_oe & shared_port_group_b_out);
      chk("s1_in", 4'h1, {2'h0, serial1_clock_in, serial1_data_in});
      serial0_mode = pinctl_pkg::S0_OFF;
      serial1_enable = 1'b0;
   endtask

   task automatic t_enable;
      {pll_sw_enable, enable_pin} = 2'h3;
      step(5);
      chk("pll", 4'h1, {3'h0, pll_enable});
      tick(hits);
      chk("ce_rst", 4'h1, hits[3:0]);
      chk("d_oe", 4'h7, {1'b0, three_bit_port_oe});
      enable_pin = 1'b0;
      hits = 0;
      repeat (6)
      begin
         step(1);
         hits += ce_int;
      end
      chk("ce_int", 4'h1, hits[3:0]);
      chk("pll", 4'h0, {3'h0, pll_enable});
      {ce_reset_delay, enable_pin} = 5'h5;
      step(5);
      tick(hits);
      chk("dly1", 4'h0, hits[3:0]);
      tick(hits);
      chk("dly2", 4'h0, hits[3:0]);
      tick(hits);
      chk("dly3", 4'h1, hits[3:0]);
      pll_sw_enable = 1'b0;
      step(2);
      chk("pll", 4'h0, {3'h0, pll_enable});
      reset_n = 1'b0;
      step(1);
      reset_n = 1'b1;
      chk("d_oe", 4'h0, {1'b0, three_bit_port_oe});
   endtask

   // =====
   // Run
   always @(posedge core_clk)
   begin
      cyc++;
      if (cyc == 2000)
      begin
         mismatches++;
         report_and_stop;
      end
   end

   initial
   begin
      {reset_n, watchdog_stack_reset, clock_stopped, dir_we, data_we, serial1_enable,
       sda_drive_low, scl_drive_low, serial0_clock_out, serial0_clock_is_out,
       serial0_data_out, serial1_clock_out, serial1_clock_is_out, serial1_data_out,
       enable_pin, timer_pulse, pll_sw_enable, wdata, ce_reset_delay} = '0;
      clk_en = 1'b1;
      port_sel = pinctl_pkg::SEL_A;
      serial0_mode = pinctl_pkg::S0_OFF;
      {ext_a, ext_b, ext_d} = 11'h7da;
      step(8);
      reset_n = 1'b1;
      step(2);
      t_ports;
      t_hold_wdt;
      t_serial;
      t_enable;
      report_and_stop;
   end
endmodule
